// >>> design/cfo_ctrl.sv
// Link controller: APB registers driving block write and read
`timescale 1ns/1ns
module cfo_ctrl #(
  parameter int QTR = cfo_pkg::QTR_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link
  cfo_link_if.ctl          link
);
  // Target answers about 5 cycles after a falling edge
  if (QTR < 4) begin : g_chk
    $error("QTR too small for target latency");
  end

  logic        sda_s;
  logic        acc;
  logic        hit;
  logic [31:0] rd_mux;
  logic        go_r, go_nxt;
  logic        dir_r, dir_nxt;
  logic [1:0]  cnt_r, cnt_nxt;
  logic [23:0] wdat_r, wdat_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic        nack_r, nack_nxt;
  cfo_pkg::cfo_cstate_type cs_r, cs_nxt;
  cfo_pkg::cfo_kind_type   kind_r, kind_nxt;
  logic [1:0]  n_r, n_nxt;
  logic [1:0]  q_r, q_nxt;
  logic [7:0]  qc_r, qc_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic        ack_r, ack_nxt;
  logic        scl_r, scl_nxt;
  logic        oe_r, oe_nxt;
  logic        busy;
  logic        is_tx;
  logic        last;
  logic [7:0]  ld;

  cfo_sync #(.W(1)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (link.sda),
    .q       (sda_s)
  );

  assign link.scl        = scl_r;
  assign link.ctl_sda_o  = 1'b0;
  assign link.ctl_sda_oe = oe_r;
  assign busy  = go_r | (cs_r != cfo_pkg::CS_IDLE);
  assign acc   = psel & penable & pready;
  assign is_tx = (kind_r != cfo_pkg::CK_RCNT) && (kind_r != cfo_pkg::CK_DATAR);
  // Count bytes end the frame on a zero count; data bytes end on their own index
  assign last  = (kind_r == cfo_pkg::CK_RCNT || kind_r == cfo_pkg::CK_CNT) ?
                 (cnt_r == 2'd0) : (n_r + 2'd1 == cnt_r);

  always_comb begin
    hit = 1'b1;
    case (paddr)
      cfo_pkg::OFS_CTRL:   rd_mux = {28'h0000000, cnt_r, dir_r, 1'b0};
      cfo_pkg::OFS_WDATA:  rd_mux = {8'h00, wdat_r};
      cfo_pkg::OFS_STATUS: rd_mux = {30'h00000000, nack_r, busy};
      cfo_pkg::OFS_RDATA:  rd_mux = rdat_r;
      default: begin
        rd_mux = 32'h00000000;
        hit    = 1'b0;
      end
    endcase
  end

  // APB register group: one wait state, then the access completes
  always_comb begin
    go_nxt   = 1'b0;
    dir_nxt  = dir_r;
    cnt_nxt  = cnt_r;
    wdat_nxt = wdat_r;
    if (acc && pwrite && paddr == cfo_pkg::OFS_WDATA) begin
      wdat_nxt = pwdata[23:0];
    end
    // Start while busy is ignored so a frame is never torn
    if (acc && pwrite && paddr == cfo_pkg::OFS_CTRL && !busy) begin
      dir_nxt = pwdata[cfo_pkg::CTRL_DIR];
      cnt_nxt = pwdata[cfo_pkg::CTRL_CNT +: 2];
      go_nxt  = pwdata[cfo_pkg::CTRL_START];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_r    <= 1'b0;
      dir_r   <= 1'b0;
      cnt_r   <= cfo_pkg::CNT_RST;
      wdat_r  <= 24'h000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      go_r    <= go_nxt;
      dir_r   <= dir_nxt;
      cnt_r   <= cnt_nxt;
      wdat_r  <= wdat_nxt;
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      prdata  <= (psel & penable & ~pready) ? rd_mux : 32'h00000000;
    end
  end

  // Link engine: each bit, start or stop is four quarters of the link clock
  always_comb begin
    cs_nxt   = cs_r;
    kind_nxt = kind_r;
    n_nxt    = n_r;
    q_nxt    = q_r;
    qc_nxt   = qc_r;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    ack_nxt  = ack_r;
    scl_nxt  = scl_r;
    oe_nxt   = oe_r;
    rdat_nxt = rdat_r;
    nack_nxt = nack_r;
    ld       = 8'h00;
    if (cs_r == cfo_pkg::CS_IDLE) begin
      if (go_r) begin
        cs_nxt   = cfo_pkg::CS_START;
        kind_nxt = cfo_pkg::CK_ADDRW;
        nack_nxt = 1'b0;
        q_nxt    = 2'd0;
        qc_nxt   = 8'h00;
        oe_nxt   = 1'b0;
      end
    end else if (qc_r != 8'(QTR - 1)) begin
      qc_nxt = qc_r + 8'h01;
    end else begin
      qc_nxt = 8'h00;
      q_nxt  = q_r + 2'd1;
      case (q_r)
        2'd0: scl_nxt = 1'b1;
        2'd1: begin
          if (cs_r == cfo_pkg::CS_START || cs_r == cfo_pkg::CS_RSTART) oe_nxt = 1'b1;
          if (cs_r == cfo_pkg::CS_STOP) oe_nxt = 1'b0;
        end
        2'd2: begin
          if (cs_r != cfo_pkg::CS_STOP) scl_nxt = 1'b0;
          if (cs_r == cfo_pkg::CS_BYTE && bit_r == 4'd8) ack_nxt = ~sda_s;
          if (cs_r == cfo_pkg::CS_BYTE && bit_r != 4'd8 && !is_tx) sh_nxt = {sh_r[6:0], sda_s};
        end
        default: begin
          if (cs_r == cfo_pkg::CS_STOP) begin
            cs_nxt = cfo_pkg::CS_IDLE;
          end else if (cs_r == cfo_pkg::CS_BYTE && bit_r != 4'd8) begin
            bit_nxt = bit_r + 4'd1;
            if (bit_r != 4'd7) begin
              // Received bits already entered at the sample point
              sh_nxt = is_tx ? {sh_r[6:0], 1'b0} : sh_r;
              oe_nxt = is_tx & ~sh_r[6];
            end else begin
              oe_nxt = ~is_tx & ~last;
            end
          end else begin
            // Pick the next token after a start or a finished byte
            cs_nxt = cfo_pkg::CS_BYTE;
            if (cs_r == cfo_pkg::CS_RSTART) begin
              kind_nxt = cfo_pkg::CK_ADDRR;
            end else if (cs_r == cfo_pkg::CS_BYTE) begin
              case (kind_r)
                cfo_pkg::CK_ADDRW: kind_nxt = cfo_pkg::CK_CMD;
                cfo_pkg::CK_CMD: begin
                  kind_nxt = cfo_pkg::CK_CNT;
                  if (dir_r) cs_nxt = cfo_pkg::CS_RSTART;
                end
                cfo_pkg::CK_ADDRR: kind_nxt = cfo_pkg::CK_RCNT;
                cfo_pkg::CK_RCNT: begin
                  rdat_nxt[7:0] = sh_r;
                  kind_nxt      = cfo_pkg::CK_DATAR;
                  n_nxt         = 2'd0;
                end
                cfo_pkg::CK_DATAR: begin
                  rdat_nxt[{n_r, 3'b000} + 5'd8 +: 8] = sh_r;
                  n_nxt = n_r + 2'd1;
                end
                cfo_pkg::CK_CNT: begin
                  kind_nxt = cfo_pkg::CK_DATAW;
                  n_nxt    = 2'd0;
                end
                default: n_nxt = n_r + 2'd1;
              endcase
              if (kind_r != cfo_pkg::CK_ADDRW && kind_r != cfo_pkg::CK_ADDRR &&
                  kind_r != cfo_pkg::CK_CMD && last) cs_nxt = cfo_pkg::CS_STOP;
              if (kind_r == cfo_pkg::CK_CNT && cnt_r == 2'd0) cs_nxt = cfo_pkg::CS_STOP;
              if (is_tx && !ack_r) begin
                nack_nxt = 1'b1;
                cs_nxt   = cfo_pkg::CS_STOP;
              end
            end
            case (kind_nxt)
              cfo_pkg::CK_ADDRW: ld = cfo_pkg::ADDR_WR_BYTE;
              cfo_pkg::CK_CMD:   ld = cfo_pkg::CMD_BLOCK;
              cfo_pkg::CK_CNT:   ld = {6'h00, cnt_r};
              cfo_pkg::CK_DATAW: ld = wdat_r[{n_nxt, 3'b000} +: 8];
              cfo_pkg::CK_ADDRR: ld = cfo_pkg::ADDR_RD_BYTE;
              default:           ld = 8'h00;
            endcase
            bit_nxt = 4'd0;
            sh_nxt  = ld;
            if (cs_nxt == cfo_pkg::CS_STOP) begin
              oe_nxt = 1'b1;
            end else if (cs_nxt == cfo_pkg::CS_RSTART) begin
              oe_nxt = 1'b0;
            end else begin
              oe_nxt = (kind_nxt != cfo_pkg::CK_RCNT) && (kind_nxt != cfo_pkg::CK_DATAR) && !ld[7];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_r   <= cfo_pkg::CS_IDLE;
      kind_r <= cfo_pkg::CK_ADDRW;
      n_r    <= 2'd0;
      q_r    <= 2'd0;
      qc_r   <= 8'h00;
      bit_r  <= 4'd0;
      sh_r   <= 8'h00;
      ack_r  <= 1'b0;
      scl_r  <= 1'b1;
      oe_r   <= 1'b0;
      rdat_r <= 32'h00000000;
      nack_r <= 1'b0;
    end else begin
      cs_r   <= cs_nxt;
      kind_r <= kind_nxt;
      n_r    <= n_nxt;
      q_r    <= q_nxt;
      qc_r   <= qc_nxt;
      bit_r  <= bit_nxt;
      sh_r   <= sh_nxt;
      ack_r  <= ack_nxt;
      scl_r  <= scl_nxt;
      oe_r   <= oe_nxt;
      rdat_r <= rdat_nxt;
      nack_r <= nack_nxt;
    end
  end
endmodule : cfo_ctrl

// >>> design/cfo_sync.sv
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
module cfo_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      q    <= '0;
    end else begin
      s1_r <= d;
      q    <= s1_r;
    end
  end
endmodule : cfo_sync

// >>> design/cfo_target.sv
// Fan-out target: two-wire block port and output-enable bank
// What this block does
// - Answer only address 11010010, R/W last
// - Only block write and block read
// - Block write framing; acknowledge every byte
// - Command byte zero selects block operation
// - Block read: restart, count, data, nack
// - Ascending byte order, MSB first
// - Stop anytime; keep whole bytes only
// - Sample data on serial clock edges
// - First byte enables pairs 0-7
// - Second byte enables pairs 8,9
// - Third byte reserved, reads all ones
// - Disabled pair goes high impedance
// - Feedback output always driven
// - Enable changes only at clock boundary
// - Registers take defaults at power-up
// - Fan out reference, true and complement
`timescale 1ns/1ns
module cfo_target (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // Serial link
  cfo_link_if.dev                            link,
  // Clock fan-out
  input  wire logic                          ref_clock_in,
  output logic      [cfo_pkg::NUM_PAIRS-1:0] out_true,
  output logic      [cfo_pkg::NUM_PAIRS-1:0] out_complement,
  output logic      [cfo_pkg::NUM_PAIRS-1:0] out_oe,
  output logic                               feedback_clock_out
);
  localparam int NP = cfo_pkg::NUM_PAIRS;

  logic                   scl_s;
  logic                   sda_s;
  logic                   ref_s;
  logic                   scl_p_r;
  logic                   sda_p_r;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_det;
  logic                   stop_det;
  cfo_pkg::cfo_tstate_type st_r, st_nxt;
  logic [1:0]             kind_r, kind_nxt;
  logic [3:0]             bit_r, bit_nxt;
  logic [7:0]             sh_r, sh_nxt;
  logic                   rw_r, rw_nxt;
  logic [1:0]             idx_r, idx_nxt;
  logic                   mack_r, mack_nxt;
  logic                   sda_oe_r, sda_oe_nxt;
  logic [7:0]             en_lo_r, en_lo_nxt;
  logic [7:0]             en_hi_r, en_hi_nxt;
  logic [7:0]             rd_byte;
  logic [NP-1:0]          en_vec;
  logic [NP-1:0]          en_act_r, en_act_nxt;

  cfo_sync #(.W(3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({link.scl, link.sda, ref_clock_in}),
    .q       ({scl_s, sda_s, ref_s})
  );

  assign scl_rise  = scl_s & ~scl_p_r;
  assign scl_fall  = ~scl_s & scl_p_r;
  assign start_det = scl_s & scl_p_r & sda_p_r & ~sda_s;
  assign stop_det  = scl_s & scl_p_r & ~sda_p_r & sda_s;
  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = sda_oe_r;

  // read image, test byte fixed at ones
  always_comb begin
    case (idx_r)
      2'd0:    rd_byte = en_lo_r;
      2'd1:    rd_byte = en_hi_r;
      2'd2:    rd_byte = cfo_pkg::TEST_RST;
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    st_nxt     = st_r;
    kind_nxt   = kind_r;
    bit_nxt    = bit_r;
    sh_nxt     = sh_r;
    rw_nxt     = rw_r;
    idx_nxt    = idx_r;
    mack_nxt   = mack_r;
    sda_oe_nxt = sda_oe_r;
    en_lo_nxt  = en_lo_r;
    en_hi_nxt  = en_hi_r;
    case (st_r)
      cfo_pkg::TS_IDLE: begin
        sda_oe_nxt = 1'b0;
      end
      cfo_pkg::TS_RX: begin
        if (scl_rise && bit_r < 4'd8) begin
          sh_nxt  = {sh_r[6:0], sda_s};
          bit_nxt = bit_r + 4'd1;
        end else if (scl_fall && bit_r == 4'd8) begin
          st_nxt     = cfo_pkg::TS_ACK;
          sda_oe_nxt = 1'b1;
          case (kind_r)
            cfo_pkg::TK_ADDR: begin
              if (sh_r[7:1] == cfo_pkg::TGT_ADDR7) begin
                rw_nxt = sh_r[0];
              end else begin
                st_nxt     = cfo_pkg::TS_IDLE;
                sda_oe_nxt = 1'b0;
              end
            end
            cfo_pkg::TK_CMD: begin
              idx_nxt = 2'd0;
              if (sh_r != cfo_pkg::CMD_BLOCK) begin
                st_nxt     = cfo_pkg::TS_IDLE;
                sda_oe_nxt = 1'b0;
              end
            end
            cfo_pkg::TK_CNT: begin
              idx_nxt = 2'd0;
            end
            default: begin
              if (idx_r == 2'd0) begin
                en_lo_nxt = sh_r;
              end
              if (idx_r == 2'd1) begin
                en_hi_nxt = sh_r & cfo_pkg::EN_HI_MASK;
              end
              // bytes past the bank acknowledged, dropped
              if (idx_r != 2'd3) begin
                idx_nxt = idx_r + 2'd1;
              end
            end
          endcase
        end
      end
      cfo_pkg::TS_ACK: begin
        // ack held through the ninth clock
        if (scl_fall) begin
          sda_oe_nxt = 1'b0;
          bit_nxt    = 4'd0;
          if (kind_r == cfo_pkg::TK_ADDR && rw_r) begin
            st_nxt     = cfo_pkg::TS_TX;
            sh_nxt     = cfo_pkg::REG_COUNT;
            sda_oe_nxt = ~cfo_pkg::REG_COUNT[7];
            idx_nxt    = 2'd0;
          end else begin
            st_nxt = cfo_pkg::TS_RX;
            if (kind_r != cfo_pkg::TK_DATA) begin
              kind_nxt = kind_r + 2'd1;
            end
          end
        end
      end
      cfo_pkg::TS_TX: begin
        if (scl_fall) begin
          if (bit_r == 4'd7) begin
            sda_oe_nxt = 1'b0;
            st_nxt     = cfo_pkg::TS_MACK;
          end else begin
            bit_nxt    = bit_r + 4'd1;
            sh_nxt     = {sh_r[6:0], 1'b0};
            sda_oe_nxt = ~sh_r[6];
          end
        end
      end
      cfo_pkg::TS_MACK: begin
        if (scl_rise) begin
          mack_nxt = ~sda_s;
        end else if (scl_fall) begin
          bit_nxt = 4'd0;
          if (mack_r) begin
            st_nxt     = cfo_pkg::TS_TX;
            sh_nxt     = rd_byte;
            sda_oe_nxt = ~rd_byte[7];
            if (idx_r != 2'd3) begin
              idx_nxt = idx_r + 2'd1;
            end
          end else begin
            st_nxt = cfo_pkg::TS_IDLE;
          end
        end
      end
      default: begin
        st_nxt     = cfo_pkg::TS_IDLE;
        sda_oe_nxt = 1'b0;
      end
    endcase
    // start or stop drops any partial byte
    if (start_det) begin
      st_nxt     = cfo_pkg::TS_RX;
      kind_nxt   = cfo_pkg::TK_ADDR;
      bit_nxt    = 4'd0;
      sda_oe_nxt = 1'b0;
    end else if (stop_det) begin
      st_nxt     = cfo_pkg::TS_IDLE;
      sda_oe_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_p_r  <= 1'b0;
      sda_p_r  <= 1'b0;
      st_r     <= cfo_pkg::TS_IDLE;
      kind_r   <= cfo_pkg::TK_ADDR;
      bit_r    <= 4'd0;
      sh_r     <= 8'h00;
      rw_r     <= 1'b0;
      idx_r    <= 2'd0;
      mack_r   <= 1'b0;
      sda_oe_r <= 1'b0;
      en_lo_r  <= cfo_pkg::EN_LO_RST;
      en_hi_r  <= cfo_pkg::EN_HI_RST;
    end else begin
      scl_p_r  <= scl_s;
      sda_p_r  <= sda_s;
      st_r     <= st_nxt;
      kind_r   <= kind_nxt;
      bit_r    <= bit_nxt;
      sh_r     <= sh_nxt;
      rw_r     <= rw_nxt;
      idx_r    <= idx_nxt;
      mack_r   <= mack_nxt;
      sda_oe_r <= sda_oe_nxt;
      en_lo_r  <= en_lo_nxt;
      en_hi_r  <= en_hi_nxt;
    end
  end

  // Pair i maps to a descending bit of the bank
  for (genvar i = 0; i < NP; i++) begin : g_map
    if (i < 8) begin : g_lo
      assign en_vec[i] = en_lo_r[7-i];
    end else begin : g_hi
      assign en_vec[i] = en_hi_r[15-i];
    end
  end

  always_comb begin
    en_act_nxt = ref_s ? en_act_r : en_vec;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_act_r           <= '1;
      out_true           <= '0;
      out_complement     <= '1;
      out_oe             <= '1;
      feedback_clock_out <= 1'b0;
    end else begin
      en_act_r           <= en_act_nxt;
      out_true           <= {NP{ref_s}};
      out_complement     <= {NP{~ref_s}};
      out_oe             <= en_act_nxt;
      feedback_clock_out <= ref_s;
    end
  end
endmodule : cfo_target

// >>> inc/cfo_link_if.sv
// Two-wire link between controller and fan-out target
`timescale 1ns/1ns
interface cfo_link_if;
  logic scl;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Open-drain line with pull-up
  assign sda = (ctl_sda_oe ? ctl_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport ctl (output scl, output ctl_sda_o, output ctl_sda_oe, input sda);
  modport dev (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface : cfo_link_if

// >>> inc/cfo_pkg.sv
// Shared constants and types for the clock fan-out enable link
package cfo_pkg;
  // Serial link framing
  localparam logic [6:0] TGT_ADDR7      = 7'h69;
  localparam logic [7:0] ADDR_WR_BYTE   = 8'hd2;
  localparam logic [7:0] ADDR_RD_BYTE   = 8'hd3;
  localparam logic [7:0] CMD_BLOCK      = 8'h00;
  localparam logic [7:0] REG_COUNT      = 8'h03;
  // Enable register bank
  localparam int         NUM_PAIRS      = 10;
  localparam logic [7:0] EN_LO_RST      = 8'hff;
  localparam logic [7:0] EN_HI_RST      = 8'hc0;
  localparam logic [7:0] EN_HI_MASK     = 8'hc0;
  localparam logic [7:0] TEST_RST       = 8'hff;
  // Link timing
  localparam int         PCLK_PERIOD_NS = 10;
  localparam int         LINK_PERIOD_NS = 160;
  localparam int         QTR_CYC        = LINK_PERIOD_NS / PCLK_PERIOD_NS / 4;
  // Controller APB map
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_WDATA      = 8'h04;
  localparam logic [7:0] OFS_STATUS     = 8'h08;
  localparam logic [7:0] OFS_RDATA      = 8'h0c;
  localparam int         CTRL_START     = 0;
  localparam int         CTRL_DIR       = 1;
  localparam int         CTRL_CNT       = 2;
  localparam int         STAT_BUSY      = 0;
  localparam int         STAT_NACK      = 1;
  localparam logic [1:0] CNT_RST        = 2'h3;
  // Byte roles seen by the target
  localparam logic [1:0] TK_ADDR        = 2'h0;
  localparam logic [1:0] TK_CMD         = 2'h1;
  localparam logic [1:0] TK_CNT         = 2'h2;
  localparam logic [1:0] TK_DATA        = 2'h3;
  // Byte roles sent or received by the controller; engine states
  typedef enum logic [2:0] {
    CK_ADDRW, CK_CMD, CK_CNT, CK_DATAW, CK_ADDRR, CK_RCNT, CK_DATAR
  } cfo_kind_type;
  typedef enum logic [4:0] {
    TS_IDLE = 5'b00001, TS_RX = 5'b00010, TS_ACK = 5'b00100,
    TS_TX = 5'b01000, TS_MACK = 5'b10000
  } cfo_tstate_type;
  typedef enum logic [4:0] {
    CS_IDLE = 5'b00001, CS_START = 5'b00010, CS_BYTE = 5'b00100,
    CS_RSTART = 5'b01000, CS_STOP = 5'b10000
  } cfo_cstate_type;
endpackage : cfo_pkg

// >>> testbench/cfo_link_checker.sv
// Protocol assertions on the two-wire enable link
`timescale 1ns/1ns
module cfo_link_checker (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // Link wires
  input logic scl,
  input logic sda,
  input logic ctl_sda_oe,
  input logic dev_sda_oe
);
  logic [3:0] hi_cnt_r;
  logic [3:0] hi_cnt_nxt;

  // Saturating count of scl high cycles marks an idle link
  always_comb begin
    hi_cnt_nxt = scl ? hi_cnt_r + {3'h0, hi_cnt_r != 4'hf} : 4'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hi_cnt_r <= 4'h0;
    else
      hi_cnt_r <= hi_cnt_nxt;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start; scl && $past(scl) && $fell(sda); endsequence
  sequence s_stop; scl && $past(scl) && $rose(sda); endsequence
  property p_scl_high; $rose(scl) |-> scl [*7]; endproperty
  property p_scl_low; $fell(scl) |-> (!scl) [*7]; endproperty
  property p_dev_edge; $changed(dev_sda_oe) |-> !scl; endproperty
  property p_ack_len; $rose(dev_sda_oe) |-> dev_sda_oe [*8]; endproperty
  property p_start; s_start |-> ##[1:8] $fell(scl); endproperty
  property p_stop; s_stop |-> scl [*3]; endproperty
  property p_ctl_edge; $changed(ctl_sda_oe) && scl |-> $past(scl, 3); endproperty
  property p_dev_idle; hi_cnt_r == 4'hf |-> !dev_sda_oe; endproperty
  a_scl_high: assert property (p_scl_high) else $error("scl high short");
  a_scl_low: assert property (p_scl_low) else $error("scl low short");
  a_dev_edge: assert property (p_dev_edge) else $error("target moved sda with scl high");
  a_ack_len: assert property (p_ack_len) else $error("target low bit too short");
  a_start: assert property (p_start) else $error("start not followed by scl fall");
  a_stop: assert property (p_stop) else $error("scl not held after stop");
  a_ctl_edge: assert property (p_ctl_edge) else $error("controller moved sda in mid bit");
  a_dev_idle: assert property (p_dev_idle) else $error("target drives idle link");
endmodule : cfo_link_checker

// >>> testbench/tb_top.sv
// Self-checking bench: APB controller and fan-out target on one link
`timescale 1ns/1ns
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, lo, hi;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        ref_clock_in, feedback_clock_out;
  logic [9:0]  out_true, out_complement, out_oe, prev_oe;
  int          failures, tests_run, cyc;

  cfo_link_if link ();
  cfo_ctrl cfo_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  cfo_target cfo_target_inst (.pclk(pclk), .presetn(presetn), .link(link), .ref_clock_in(ref_clock_in),
    .out_true(out_true), .out_complement(out_complement), .out_oe(out_oe),
    .feedback_clock_out(feedback_clock_out));
  cfo_link_checker cfo_link_checker_inst (.pclk(pclk), .presetn(presetn), .scl(link.scl), .sda(link.sda),
    .ctl_sda_oe(link.ctl_sda_oe), .dev_sda_oe(link.dev_sda_oe));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic frame(input logic [31:0] ctrl);
    apb(1'b1, cfo_pkg::OFS_CTRL, ctrl);
    do apb(1'b0, cfo_pkg::OFS_STATUS, 32'h0); while (rd[cfo_pkg::STAT_BUSY] !== 1'b0);
    chk({31'h0, rd[cfo_pkg::STAT_NACK]}, 32'h0);
  endtask : frame

  function automatic logic [9:0] exp_oe();
    logic [9:0] e;
    for (int i = 0; i < 8; i++) e[i] = lo[7-i];
    e[8] = hi[7];
    e[9] = hi[6];
    return e;
  endfunction : exp_oe

  // Model keeps only the whole bytes the frame carried
  task automatic wr(input int c, input logic [31:0] w);
    apb(1'b1, cfo_pkg::OFS_WDATA, w);
    frame({28'h0, c[1:0], 2'h1});
    if (c > 0)
      lo = w[7:0];
    if (c > 1)
      hi = w[15:8] & cfo_pkg::EN_HI_MASK;
    chk(out_oe, exp_oe());
  endtask : wr

  // Only the bytes the read asked for are compared
  task automatic rdback(input int c);
    logic [31:0] m;
    m = (32'h1 << (8 * (c + 1))) - 32'h1;
    frame({28'h0, c[1:0], 2'h3});
    apb(1'b0, cfo_pkg::OFS_RDATA, 32'h0);
    chk(rd & m, {cfo_pkg::TEST_RST, hi, lo, cfo_pkg::REG_COUNT} & m);
  endtask : rdback

  // Reference driven off the bus clock at an 80 ns period
  initial begin
    ref_clock_in = 1'b0;
    forever begin
      repeat (4) @(posedge pclk);
      ref_clock_in <= ~ref_clock_in;
    end
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    prev_oe <= out_oe;
    if (presetn === 1'b1) begin
      chk(out_complement ^ out_true, 10'h3ff);
      chk(out_true, {10{feedback_clock_out}});
      if (out_oe !== prev_oe)
        chk(feedback_clock_out, 1'b0);
    end
    if (cyc == 80000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h22eb;
    lo = cfo_pkg::EN_LO_RST;
    hi = cfo_pkg::EN_HI_RST;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(out_oe, 10'h3ff);
    rdback(3);
    // all pairs off, then reserved bits
    wr(3, 32'h0);
    rdback(3);
    wr(3, 32'hffffffff);
    for (int i = 0; i < 8; i++) begin
      wr(int'(rnd() % 4), rnd());
      rdback(i % 4);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    end_of_test();
  end
endmodule : tb_top
